//--- shared/gdh_pkg.sv
// constants, field positions and carrier types for the digital i/o handshake block
// assumes one 125 MHz clock; front end and parser live elsewhere
package gdh_pkg;
  // clock and pulse timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int LONG_PULSE_NS = 50000;
  localparam int SHORT_PULSE_NS = 15000;
  localparam int LONG_PULSE_CYCLES = (LONG_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SHORT_PULSE_CYCLES = (SHORT_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 16;
  // inhibit hold lets the synchronised port inputs settle
  localparam int INHIBIT_HOLD_CYCLES = 4;
  localparam int INH_W = 3;
  localparam int PORT_BITS = 40;
  localparam int PORT_COUNT = 5;
  // format codes
  localparam logic [2:0] FMT_DEFAULT_TEXT = 3'h0;
  localparam logic [2:0] FMT_FIXED_FIVE = 3'h4;
  localparam logic [2:0] FMT_FAST_BINARY = 3'h5;
  // invert field bit positions (bit n carries weight 2**n)
  localparam int INV_INHIBIT = 0;
  localparam int INV_TRIGGER = 1;
  localparam int INV_STROBE = 2;
  localparam int INV_CLEAR = 3;
  localparam int INV_READY_EDGE = 5;
  localparam int INV_SERVICE = 6;
  // handshake pulse arguments
  localparam logic [1:0] HS_PULSE_CLEAR = 2'h0;
  localparam logic [1:0] HS_PULSE_STROBE = 2'h1;
  localparam logic [1:0] HS_PULSE_TRIGGER = 2'h2;
  // serial poll status byte layout
  localparam int SPOLL_RSV_BIT = 6;
  localparam int SPOLL_OVERRUN_BIT = 0;
  localparam logic [39:0] PORT_RESET = 40'h00_0000_0000;

  typedef struct packed {
    logic [2:0] format_select;
    logic read_mode_select;
    logic [6:0] invert;
    logic service_request_enable;
    logic [7:0] term_first;
    logic [7:0] term_second;
    logic [1:0] term_count;
  } gdh_cfg_s;

  localparam gdh_cfg_s CFG_RESET = '{
    format_select: 3'h0,
    read_mode_select: 1'b0,
    invert: 7'h00,
    service_request_enable: 1'b0,
    term_first: 8'h0d,
    term_second: 8'h0a,
    term_count: 2'h2
  };

  // one-cycle bus event strobes from the bus front end
  typedef struct packed {
    logic my_talk;
    logic my_listen;
    logic untalk;
    logic unlisten;
    logic dev_clear;
    logic if_clear;
    logic group_trigger;
    logic spoll_enable;
    logic spoll_disable;
  } gdh_bus_evt_s;

  typedef struct packed {
    logic [7:0] data;
    logic eoi;
  } gdh_byte_s;

  typedef enum logic [6:0] {
    T_IDLE = 7'h01,
    T_INHIBIT = 7'h02,
    T_SEND = 7'h04,
    T_TERM = 7'h08,
    T_DONE = 7'h10,
    T_SPOLL = 7'h20,
    T_SPARE = 7'h40
  } gdh_talk_e;
endpackage

//--- verilog/gdh_digital_io.sv
// handshake lines, read sequencing and bus events of the digital i/o unit
// assumes one-cycle bus event strobes; port and line inputs are pins
//
// Notes on behaviour
// - clear pulses 50us on clears
// - handshake command pulses one line
// - strobe pulses on new output data
// - ready edge latches, not in fast
// - inhibit during port read or drive
// - fast re-reads, inhibit N+1 times
// - trigger pulses on group trigger
// - service edge raises service request
// - no remote, local or parallel poll
// - unlatched talk reads, sends, needs readdress
// - second latch edge overruns
// - status leaves ports and inhibit alone
// - fast talk: eoi fifth byte, repeatable
// - bytes go out top port first
// - text listen feeds the interpreter
// - fast listen strobes per five bytes
// - early eoi updates received ports
// - device clear restores defaults
// - device clear leaves fast, no pulse
// - interface clear idles both, pulses clear
// - accepted poll byte clears requests
// - unlisten and untalk idle
`timescale 1ns/1ns
module gdh_digital_io #(
  parameter int LONG_PULSE_CYCLES = gdh_pkg::LONG_PULSE_CYCLES
)
(
  input wire logic clock,
  input wire logic rstn,
  input wire gdh_pkg::gdh_bus_evt_s bus_evt,
  input wire logic cfg_wr,
  input wire gdh_pkg::gdh_cfg_s cfg_wdata,
  output gdh_pkg::gdh_cfg_s cfg_state,
  input wire logic handshake_pulse_cmd,
  input wire logic [1:0] handshake_arg,
  input wire logic inhibit_drive_cmd,
  input wire logic status_query_cmd,
  input wire logic [7:0] status_byte,
  input wire logic new_data_out,
  input wire logic [39:0] port_wr_data,
  input wire logic rx_valid,
  input wire gdh_pkg::gdh_byte_s rx_byte,
  output logic rx_ready,
  output logic cmd_valid,
  output logic [7:0] cmd_byte,
  input wire logic cmd_ready,
  output logic tx_valid,
  output gdh_pkg::gdh_byte_s tx_byte,
  input wire logic tx_ready,
  input wire logic [39:0] port_in,
  input wire logic ext_ready_in,
  input wire logic service_in,
  output logic [39:0] port_out,
  output logic clear_out,
  output logic strobe_out,
  output logic trigger_out,
  output logic inhibit_out,
  output logic srq_out,
  output logic overrun_err,
  output logic defaults_restore,
  output logic talker_active,
  output logic listener_active
);
  localparam int CW = gdh_pkg::CNT_W;
  localparam int IW = gdh_pkg::INH_W;
  localparam logic [CW-1:0] LONG_LEN = CW'(LONG_PULSE_CYCLES);
  localparam logic [CW-1:0] SHORT_LEN = CW'(gdh_pkg::SHORT_PULSE_CYCLES);
  localparam logic [IW-1:0] INH_LEN = IW'(gdh_pkg::INHIBIT_HOLD_CYCLES);

  // countdown shared by the timed lines
  function automatic logic [CW-1:0] pulse_next(input logic [CW-1:0] cnt, input logic start,
                                               input logic [CW-1:0] len);
    if (start)
      return len;
    else if (cnt != '0)
      return cnt - 1'b1;
    else
      return cnt;
  endfunction

  // rising edge, or falling when inverted
  function automatic logic edge_of(input logic now, input logic prev, input logic inv);
    return inv ? (prev & ~now) : (now & ~prev);
  endfunction

  gdh_pkg::gdh_cfg_s cfg;
  gdh_pkg::gdh_talk_e state;
  logic [39:0] port_s1, port_s2;
  logic [2:0] ready_s, svc_s;
  logic fast, ready_edge, svc_edge, dcl_fast, dcl_text, go_read, load_latch, status_pending_srq;
  logic [CW-1:0] clr_cnt, stb_cnt, trg_cnt;
  logic [IW-1:0] inh_cnt;
  logic inh_start, capture_now, latch_busy, latch_full, edr_accept, edr_overrun;
  logic [39:0] latch_data, tx_shift, fb_stage;
  logic [2:0] byte_idx, fb_idx;
  logic [1:0] term_idx;
  logic status_pending, spoll_en, preloaded, overrun_flag;
  logic push_valid, push_fire, spoll_accept, send_last, rx_fire, fb_commit;
  gdh_pkg::gdh_byte_s push_byte;
  gdh_pkg::gdh_byte_s buf_mem [2];
  logic buf_wp, buf_rp;
  logic [1:0] buf_cnt;

  assign fast = (cfg.format_select == gdh_pkg::FMT_FAST_BINARY);
  assign cfg_state = cfg;
  assign dcl_fast = bus_evt.dev_clear & fast;
  assign dcl_text = bus_evt.dev_clear & ~fast;

  // two-flop synchronisers; only the second stage and later are read
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      port_s1 <= gdh_pkg::PORT_RESET;
      port_s2 <= gdh_pkg::PORT_RESET;
      ready_s <= 3'h0;
      svc_s <= 3'h0;
    end
    else
    begin
      port_s1 <= port_in;
      port_s2 <= port_s1;
      ready_s <= {ready_s[1:0], ext_ready_in};
      svc_s <= {svc_s[1:0], service_in};
    end
  end

  assign ready_edge = edge_of(ready_s[1], ready_s[2], cfg.invert[gdh_pkg::INV_READY_EDGE]);
  assign svc_edge = edge_of(svc_s[1], svc_s[2], cfg.invert[gdh_pkg::INV_SERVICE]);

  // configuration; device clear restores defaults or leaves fast
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      cfg <= gdh_pkg::CFG_RESET;
    else if (dcl_fast)
      cfg.format_select <= gdh_pkg::FMT_DEFAULT_TEXT;
    else if (dcl_text)
      cfg <= gdh_pkg::CFG_RESET;
    else if (cfg_wr)
      cfg <= cfg_wdata;
  end

  // addressing; no remote, local or parallel poll events exist
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      talker_active <= 1'b0;
      listener_active <= 1'b0;
      spoll_en <= 1'b0;
    end
    else
    begin
      if (bus_evt.if_clear || bus_evt.untalk)
        talker_active <= 1'b0;
      else if (bus_evt.my_talk)
        talker_active <= 1'b1;
      if (bus_evt.if_clear || bus_evt.unlisten)
        listener_active <= 1'b0;
      else if (bus_evt.my_listen)
        listener_active <= 1'b1;
      if (bus_evt.if_clear || bus_evt.spoll_disable)
        spoll_en <= 1'b0;
      else if (bus_evt.spoll_enable)
        spoll_en <= 1'b1;
    end
  end

  // timed output lines, one countdown each
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      clr_cnt <= '0;
      stb_cnt <= '0;
      trg_cnt <= '0;
    end
    else
    begin
      clr_cnt <= pulse_next(clr_cnt, dcl_text | bus_evt.if_clear
                 | (handshake_pulse_cmd && handshake_arg == gdh_pkg::HS_PULSE_CLEAR), LONG_LEN);
      stb_cnt <= pulse_next(stb_cnt, new_data_out | fb_commit
                 | (handshake_pulse_cmd && handshake_arg == gdh_pkg::HS_PULSE_STROBE),
                 fb_commit ? SHORT_LEN : LONG_LEN);
      trg_cnt <= pulse_next(trg_cnt, bus_evt.group_trigger
                 | (handshake_pulse_cmd && handshake_arg == gdh_pkg::HS_PULSE_TRIGGER), LONG_LEN);
    end
  end

  // registered pin levels; programmable polarity on all but srq_out
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      clear_out <= 1'b0;
      strobe_out <= 1'b0;
      trigger_out <= 1'b0;
      inhibit_out <= 1'b0;
      srq_out <= 1'b0;
    end
    else
    begin
      clear_out <= (clr_cnt != '0) ^ cfg.invert[gdh_pkg::INV_CLEAR];
      strobe_out <= (stb_cnt != '0) ^ cfg.invert[gdh_pkg::INV_STROBE];
      trigger_out <= (trg_cnt != '0) ^ cfg.invert[gdh_pkg::INV_TRIGGER];
      inhibit_out <= ((inh_cnt != '0) | inhibit_drive_cmd)
                     ^ cfg.invert[gdh_pkg::INV_INHIBIT];
      srq_out <= status_pending_srq;
    end
  end

  // latched reads; an edge while data waits is refused
  assign edr_accept = ready_edge & cfg.read_mode_select & ~fast & ~latch_full & ~latch_busy;
  assign edr_overrun = ready_edge & cfg.read_mode_select & ~fast & (latch_full | latch_busy);
  assign capture_now = (inh_cnt == IW'(1));

  // inhibit hold; ports sampled in its last cycle
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      inh_cnt <= '0;
    else if (inh_start)
      inh_cnt <= INH_LEN;
    else if (inh_cnt != '0)
      inh_cnt <= inh_cnt - 1'b1;
  end

  assign inh_start = edr_accept | ((state == gdh_pkg::T_IDLE) & go_read)
                     | ((state == gdh_pkg::T_SEND) & push_fire & send_last & fast);

  // latch of edge-captured data; capture beats a same-cycle load
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      latch_busy <= 1'b0;
      latch_full <= 1'b0;
      latch_data <= gdh_pkg::PORT_RESET;
      overrun_err <= 1'b0;
    end
    else
    begin
      overrun_err <= edr_overrun;
      if (dcl_text)
      begin
        latch_busy <= 1'b0;
        latch_full <= 1'b0;
      end
      else
      begin
        if (edr_accept)
          latch_busy <= 1'b1;
        else if (capture_now && latch_busy)
          latch_busy <= 1'b0;
        if (load_latch)
          latch_full <= 1'b0;
        if (capture_now && latch_busy)
        begin
          latch_data <= port_s2;
          latch_full <= 1'b1;
        end
      end
    end
  end

  // talker decisions taken in idle
  assign go_read = talker_active & ~spoll_en & ~status_pending
                   & (fast ? ~preloaded : ~cfg.read_mode_select);
  assign load_latch = (state == gdh_pkg::T_IDLE) & talker_active & ~spoll_en & ~status_pending
                      & ~fast & cfg.read_mode_select & latch_full;
  assign send_last = (byte_idx == 3'h4);

  // bytes offered to the output buffer
  always_comb
  begin
    push_valid = 1'b0;
    push_byte = '{data: tx_shift[39:32], eoi: 1'b0};
    case (state)
      gdh_pkg::T_IDLE:
      begin
        push_valid = talker_active & ~spoll_en & status_pending;
        push_byte = '{data: status_byte, eoi: 1'b1};
      end
      gdh_pkg::T_SPOLL:
      begin
        push_valid = 1'b1;
        push_byte.data = 8'h00;
        push_byte.data[gdh_pkg::SPOLL_RSV_BIT] = status_pending_srq;
        push_byte.data[gdh_pkg::SPOLL_OVERRUN_BIT] = overrun_flag;
      end
      gdh_pkg::T_SEND:
      begin
        push_valid = 1'b1;
        push_byte.eoi = send_last & (fast
                        | (cfg.format_select == gdh_pkg::FMT_FIXED_FIVE) | (cfg.term_count == 2'h0));
      end
      gdh_pkg::T_TERM:
      begin
        push_valid = 1'b1;
        push_byte.data = (term_idx == 2'h0) ? cfg.term_first : cfg.term_second;
        push_byte.eoi = (term_idx == cfg.term_count - 2'h1);
      end
      default:
        push_valid = 1'b0;
    endcase
  end

  assign push_fire = push_valid & (buf_cnt != 2'h2);
  assign spoll_accept = push_fire & (state == gdh_pkg::T_SPOLL);

  // talker sequencer
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      state <= gdh_pkg::T_IDLE;
      tx_shift <= gdh_pkg::PORT_RESET;
      byte_idx <= 3'h0;
      term_idx <= 2'h0;
      preloaded <= 1'b0;
    end
    else if (bus_evt.if_clear || bus_evt.untalk || dcl_text)
    begin
      state <= gdh_pkg::T_IDLE;
      byte_idx <= 3'h0;
      term_idx <= 2'h0;
      preloaded <= preloaded & ~dcl_text;
    end
    else
    begin
      case (state)
        gdh_pkg::T_IDLE:
        begin
          if (talker_active && spoll_en)
            state <= gdh_pkg::T_SPOLL;
          else if (push_fire)
            state <= gdh_pkg::T_DONE;
          else if (go_read)
            state <= gdh_pkg::T_INHIBIT;
          else if (talker_active && fast && preloaded)
          begin
            preloaded <= 1'b0;
            state <= gdh_pkg::T_SEND;
          end
          else if (load_latch)
          begin
            tx_shift <= latch_data;
            state <= gdh_pkg::T_SEND;
          end
        end
        gdh_pkg::T_INHIBIT:
        begin
          if (capture_now)
          begin
            tx_shift <= port_s2;
            preloaded <= fast & ~talker_active;
            state <= talker_active ? gdh_pkg::T_SEND : gdh_pkg::T_IDLE;
          end
        end
        gdh_pkg::T_SEND:
        begin
          if (push_fire)
          begin
            tx_shift <= {tx_shift[31:0], 8'h00};
            byte_idx <= byte_idx + 3'h1;
            if (send_last)
            begin
              byte_idx <= 3'h0;
              if (fast)
                state <= gdh_pkg::T_INHIBIT;
              else if (push_byte.eoi)
                state <= gdh_pkg::T_DONE;
              else
                state <= gdh_pkg::T_TERM;
            end
          end
        end
        gdh_pkg::T_TERM:
        begin
          if (push_fire)
          begin
            term_idx <= term_idx + 2'h1;
            if (push_byte.eoi)
            begin
              term_idx <= 2'h0;
              state <= gdh_pkg::T_DONE;
            end
          end
        end
        gdh_pkg::T_DONE:
        begin
          if (bus_evt.my_talk)
            state <= gdh_pkg::T_IDLE;
        end
        gdh_pkg::T_SPOLL:
        begin
          if (!spoll_en || !talker_active)
            state <= gdh_pkg::T_IDLE;
        end
        default:
        begin
          state <= gdh_pkg::T_IDLE;
        end
      endcase
    end
  end

  // sticky flags; an event in the clearing cycle survives
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      status_pending_srq <= 1'b0;
      overrun_flag <= 1'b0;
      status_pending <= 1'b0;
    end
    else if (dcl_text)
    begin
      status_pending_srq <= 1'b0;
      overrun_flag <= 1'b0;
      status_pending <= 1'b0;
    end
    else
    begin
      if (svc_edge && cfg.service_request_enable)
        status_pending_srq <= 1'b1;
      else if (spoll_accept)
        status_pending_srq <= 1'b0;
      if (edr_overrun)
        overrun_flag <= 1'b1;
      else if (spoll_accept)
        overrun_flag <= 1'b0;
      if (status_query_cmd)
        status_pending <= 1'b1;
      else if (push_fire && state == gdh_pkg::T_IDLE)
        status_pending <= 1'b0;
    end
  end

  // two-entry output buffer; a stall holds the talker
  assign tx_valid = (buf_cnt != 2'h0);
  assign tx_byte = buf_mem[buf_rp];
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      buf_wp <= 1'b0;
      buf_rp <= 1'b0;
      buf_cnt <= 2'h0;
      buf_mem[0] <= '0;
      buf_mem[1] <= '0;
    end
    else
    begin
      if (push_fire)
      begin
        buf_mem[buf_wp] <= push_byte;
        buf_wp <= ~buf_wp;
      end
      if (tx_valid && tx_ready)
        buf_rp <= ~buf_rp;
      buf_cnt <= buf_cnt + {1'b0, push_fire} - {1'b0, tx_valid & tx_ready};
    end
  end

  // listener: text to interpreter, fast binary to ports
  assign rx_ready = listener_active & (fast | ~cmd_valid | cmd_ready);
  assign rx_fire = rx_valid & rx_ready;
  assign fb_commit = rx_fire & fast & ((fb_idx == 3'h4) | rx_byte.eoi);

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      cmd_valid <= 1'b0;
      cmd_byte <= 8'h00;
    end
    else if (rx_fire && !fast)
    begin
      cmd_valid <= 1'b1;
      cmd_byte <= rx_byte.data;
    end
    else if (cmd_ready)
      cmd_valid <= 1'b0;
  end

  // port writes; fast binary commits only the bytes received
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      port_out <= gdh_pkg::PORT_RESET;
      fb_stage <= gdh_pkg::PORT_RESET;
      fb_idx <= 3'h0;
      defaults_restore <= 1'b0;
    end
    else
    begin
      defaults_restore <= dcl_text;
      if (dcl_text)
      begin
        port_out <= gdh_pkg::PORT_RESET;
        fb_idx <= 3'h0;
      end
      else if (dcl_fast || !listener_active)
        fb_idx <= 3'h0;
      else if (rx_fire && fast)
      begin
        fb_stage[39 - 8 * fb_idx -: 8] <= rx_byte.data;
        fb_idx <= fb_commit ? 3'h0 : fb_idx + 3'h1;
        if (fb_commit)
        begin
          for (int i = 0; i < gdh_pkg::PORT_COUNT; i++)
          begin
            if (i < fb_idx)
              port_out[39 - 8 * i -: 8] <= fb_stage[39 - 8 * i -: 8];
            else if (i == fb_idx)
              port_out[39 - 8 * i -: 8] <= rx_byte.data;
          end
        end
      end
      if (new_data_out && !dcl_text)
        port_out <= port_wr_data;
    end
  end
endmodule // gdh_digital_io

//--- tb/gdh_digital_io_properties.sv
// port assertions for the digital i/o block
// assumes binding onto gdh_digital_io, one clock, rstn active low
`timescale 1ns/1ns
module gdh_digital_io_properties #(
  parameter int LONG_PULSE_CYCLES = 20
)
(
  input wire logic clock,
  input wire logic rstn,
  input wire gdh_pkg::gdh_bus_evt_s bus_evt,
  input wire gdh_pkg::gdh_cfg_s cfg_state,
  input wire logic clear_out,
  input wire logic trigger_out,
  input wire logic tx_valid,
  input wire gdh_pkg::gdh_byte_s tx_byte,
  input wire logic tx_ready,
  input wire logic rx_ready,
  input wire logic defaults_restore,
  input wire logic talker_active,
  input wire logic listener_active
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  logic clr_act;
  logic [15:0] clr_cnt;
  // active level, whatever the invert weight
  assign clr_act = clear_out ^ cfg_state.invert[gdh_pkg::INV_CLEAR];
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      clr_cnt <= 16'h0000;
    else
      clr_cnt <= clr_act ? clr_cnt + 16'h0001 : 16'h0000;
  end
  sequence s_clear_up;
    ##2 clr_act;
  endsequence
  property p_ifc_clear; bus_evt.if_clear |-> s_clear_up; endproperty
  a_ifc_clear: assert property (p_ifc_clear) else $error("clear pulse missing");
  // skip ends near an invert change
  property p_clear_width; $fell(clr_act) && $stable(cfg_state.invert)
    && $past(cfg_state.invert) == $past(cfg_state.invert, 2) |-> clr_cnt == LONG_PULSE_CYCLES;
  endproperty
  a_clear_width: assert property (p_clear_width) else $error("clear width wrong");
  property p_get_trig;
    bus_evt.group_trigger |-> ##2 (trigger_out != cfg_state.invert[gdh_pkg::INV_TRIGGER]);
  endproperty
  a_get_trig: assert property (p_get_trig) else $error("trigger pulse missing");
  property p_dcl_restore;
    bus_evt.dev_clear && cfg_state.format_select != gdh_pkg::FMT_FAST_BINARY |=> defaults_restore;
  endproperty
  a_dcl_restore: assert property (p_dcl_restore) else $error("defaults not restored");
  property p_dcl_fast; bus_evt.dev_clear && !clr_act
    && cfg_state.format_select == gdh_pkg::FMT_FAST_BINARY |=> !clr_act [*2]; endproperty
  a_dcl_fast: assert property (p_dcl_fast) else $error("clear pulsed in fast");
  property p_untalk; bus_evt.untalk |=> !talker_active; endproperty
  a_untalk: assert property (p_untalk) else $error("talker still active");
  property p_tx_hold; tx_valid && !tx_ready |=> tx_valid && $stable(tx_byte); endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("talker byte dropped");
  property p_fast_rx; cfg_state.format_select == gdh_pkg::FMT_FAST_BINARY
    |-> rx_ready == listener_active; endproperty
  a_fast_rx: assert property (p_fast_rx) else $error("fast listener stalled");
endmodule // gdh_digital_io_properties
bind gdh_digital_io gdh_digital_io_properties #(.LONG_PULSE_CYCLES(LONG_PULSE_CYCLES))
  gdh_digital_io_properties_i (.*);

//--- tb/gdh_far_model.sv
// far side: bus controller taking talker bytes, interpreter taking commands
// assumes hold is driven by the bench just after rising edges
`timescale 1ns/1ns
module gdh_far_model
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic hold,
  output logic tx_ready,
  output logic cmd_ready
);
  logic [1:0] tick;
  // fixed stall rhythm backs the buffer up
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      tick <= 2'h0;
    else
      tick <= tick + 2'h1;
  end
  assign tx_ready = !hold && (tick != 2'h0);
  assign cmd_ready = tick[0];
endmodule // gdh_far_model

//--- tb/gdh_digital_io_test.sv
// self-checking bench for the digital i/o handshake block
// assumes the far-side model and the bound checker; one 125 MHz clock
`timescale 1ns/1ns
module gdh_digital_io_test;
  localparam int L = 20;
  logic clock = 1'b0, rstn = 1'b0, hold = 1'b0, ign = 1'b0, inh_d = 1'b0, cfg_wr = 1'b0;
  logic handshake_pulse_cmd = 1'b0, inhibit_drive_cmd = 1'b0, status_query_cmd = 1'b0;
  logic new_data_out = 1'b0, rx_valid = 1'b0, ext_ready_in = 1'b0, service_in = 1'b0;
  logic [1:0] handshake_arg = 2'h0;
  logic [7:0] status_byte = 8'h00, cmd_byte, b;
  logic [39:0] port_wr_data = '0, port_in = '0, port_out, d;
  logic [31:0] rs = 32'h0000_0024;
  logic rx_ready, cmd_valid, cmd_ready, tx_valid, tx_ready, clear_out, strobe_out, trigger_out;
  logic inhibit_out, srq_out, overrun_err, defaults_restore, talker_active, listener_active;
  gdh_pkg::gdh_bus_evt_s bus_evt = '0;
  gdh_pkg::gdh_cfg_s cfg_wdata = gdh_pkg::CFG_RESET, cfg_state, c;
  gdh_pkg::gdh_byte_s rx_byte = '0, tx_byte;
  gdh_pkg::gdh_byte_s q[$];
  int error_cnt = 0, compares = 0, inh_n = 0, ovr_n = 0, n0;
  gdh_digital_io #(.LONG_PULSE_CYCLES(L)) gdh_digital_io_i (.*);
  gdh_far_model gdh_far_model_i (.*);
  always #4 clock = ~clock;
  function automatic logic [31:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction
  task automatic chk(input string nm, input logic [39:0] seen, input logic [39:0] exp);
    compares++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask
  // one-cycle bus event; bit 8 talk .. bit 0 poll disable
  task automatic ev(input int k);
    bus_evt <= gdh_pkg::gdh_bus_evt_s'(9'h001 << k);
    cyc(1);
    bus_evt <= '0;
    cyc(1);
  endtask
  task automatic setcfg(input gdh_pkg::gdh_cfg_s v);
    cfg_wdata <= v;
    cfg_wr <= 1'b1;
    cyc(1);
    cfg_wr <= 1'b0;
    cyc(1);
  endtask
  // notes reps reads top port first, then talks
  task automatic talk(input logic [39:0] v, input logic terms, input int reps);
    for (int r = 0; r < reps; r++)
      for (int k = 4; k >= 0; k--)
        q.push_back('{v[8*k +: 8], !terms && k == 0});
    if (terms)
    begin
      q.push_back('{8'h0d, 1'b0});
      q.push_back('{8'h0a, 1'b1});
    end
    ev(8);
    repeat (4000) if (q.size() != 0) @(posedge clock);
    chk("tx_left", 40'(q.size()), 40'h0);
    hold <= ign; // freeze on expected leftovers
    ev(6);
  endtask
  task automatic rx(input logic [7:0] v, input logic e);
    rx_byte <= '{v, e};
    rx_valid <= 1'b1;
    do @(posedge clock); while (rx_ready !== 1'b1);
    rx_valid <= 1'b0;
    cyc(1);
  endtask
  // scoreboard and line counters
  always @(posedge clock)
  begin
    if (tx_valid === 1'b1 && tx_ready === 1'b1)
      if (q.size() != 0)
        chk("tx_byte", 40'(tx_byte), 40'(q.pop_front()));
      else if (!ign)
        chk("tx_extra", 40'h1, 40'h0);
    if (inhibit_out === 1'b1 && !inh_d)
      inh_n++;
    inh_d = inhibit_out;
    if (overrun_err === 1'b1)
      ovr_n++;
  end
  initial
  begin
    cyc(30000);
    error_cnt++;
    report_and_stop();
  end
  initial
  begin
    cyc(8);
    rstn <= 1'b1;
    cyc(2);
    chk("cfg_reset", 40'(cfg_state), 40'(gdh_pkg::CFG_RESET));
    // each handshake argument, plain then inverted
    for (int p = 0; p < 2; p++)
    begin
      c = gdh_pkg::CFG_RESET;
      c.invert = p ? 7'h0e : 7'h00;
      setcfg(c);
      for (int a = 0; a < 3; a++)
      begin
        handshake_arg <= 2'(a);
        handshake_pulse_cmd <= 1'b1;
        cyc(1);
        handshake_pulse_cmd <= 1'b0;
        cyc(3);
        chk("hs_on", 40'({clear_out, strobe_out, trigger_out} ^ 3'(p * 7)), 40'(3'h4 >> a));
        cyc(L + 4);
        chk("hs_off", 40'({clear_out, strobe_out, trigger_out} ^ 3'(p * 7)), 40'h0);
      end
    end
    setcfg(gdh_pkg::CFG_RESET);
    d = 40'({rnd(), rnd()});
    port_wr_data <= d;
    new_data_out <= 1'b1;
    inhibit_drive_cmd <= 1'b1;
    cyc(1);
    new_data_out <= 1'b0;
    cyc(3);
    chk("port_out", port_out, d);
    chk("inhibit", 40'(inhibit_out), 40'h1);
    inhibit_drive_cmd <= 1'b0;
    ev(3);
    ev(2);
    cyc(L + 4);
    port_in <= d;
    n0 = inh_n;
    talk(d, 1'b1, 1);
    chk("inh_once", 40'(inh_n - n0), 40'h1);
    c.format_select = gdh_pkg::FMT_FIXED_FIVE;
    setcfg(c);
    talk(d, 1'b0, 1);
    // service edge, cleared by a serial poll
    c.format_select = gdh_pkg::FMT_DEFAULT_TEXT;
    c.service_request_enable = 1'b1;
    setcfg(c);
    service_in <= 1'b1;
    cyc(8);
    chk("srq", 40'(srq_out), 40'h1);
    ign = 1'b1;
    ev(1);
    ev(8);
    repeat (50) if (tx_valid !== 1'b1) @(posedge clock);
    chk("spoll", 40'(tx_byte.data), 40'h40);
    cyc(20);
    chk("srq_clr", 40'(srq_out), 40'h0);
    ev(0);
    ev(6);
    cyc(20);
    ign = 1'b0;
    // falling-edge latch, then an overrun
    c.read_mode_select = 1'b1;
    c.invert = 7'h20;
    ext_ready_in <= 1'b1;
    setcfg(c);
    for (int k = 0; k < 2; k++)
    begin
      port_in <= k ? ~d : d;
      cyc(6);
      ext_ready_in <= 1'b0;
      cyc(10);
      ext_ready_in <= 1'b1;
      cyc(6);
    end
    chk("overrun", 40'(ovr_n), 40'h1);
    talk(d, 1'b1, 1);
    ev(4);
    cyc(2);
    chk("dcl_cfg", 40'(cfg_state), 40'(gdh_pkg::CFG_RESET));
    chk("dcl_clear", 40'(clear_out), 40'h1);
    cyc(L + 4);
    b = 8'(rnd());
    status_byte <= b;
    status_query_cmd <= 1'b1;
    cyc(1);
    status_query_cmd <= 1'b0;
    n0 = inh_n;
    q.push_back('{b, 1'b1});
    talk(d, 1'b0, 0);
    chk("inh_status", 40'(inh_n - n0), 40'h0);
    ev(7);
    rx(b, 1'b0);
    chk("cmd_byte", 40'(cmd_byte), 40'(b));
    c = gdh_pkg::CFG_RESET;
    c.format_select = gdh_pkg::FMT_FAST_BINARY;
    setcfg(c);
    d = 40'({rnd(), rnd()});
    rx(d[39:32], 1'b0);
    rx(d[31:24], 1'b1);
    cyc(4);
    chk("early_eoi", port_out, {d[39:24], 24'h00_0000});
    chk("fast_strobe", 40'(strobe_out), 40'h1);
    cyc(gdh_pkg::SHORT_PULSE_CYCLES);
    chk("fast_short", 40'(strobe_out), 40'h0);
    for (int k = 4; k >= 0; k--)
      rx(d[8*k +: 8] ^ 8'hff, 1'b0);
    cyc(4);
    chk("fast_five", port_out, ~d);
    ev(5);
    port_in <= d;
    n0 = inh_n;
    ign = 1'b1;
    talk(d, 1'b0, 2);
    cyc(10);
    chk("inh_n_plus_1", 40'(inh_n - n0), 40'h3);
    ev(4);
    cyc(4);
    chk("fast_exit", 40'(cfg_state.format_select), 40'(gdh_pkg::FMT_DEFAULT_TEXT));
    chk("no_clear", 40'(clear_out), 40'h0);
    report_and_stop();
  end
endmodule // gdh_digital_io_test
